// *** rtl/uart_cfg.svh ***
/*
 Register map, field positions, prescaler divisors and codes of the serial port.
 Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

`define ADDR_CTRL   8'h98
`define ADDR_DATA   8'h9c
`define ADDR_MODE   8'ha0
`define ADDR_BAUD   8'ha4

`define CTL_OVR     7
`define CTL_PERR    6
`define CTL_REN     4
`define CTL_TBX     3
`define CTL_TI      1
`define CTL_RI      0

`define MODE_MCE    7
`define MODE_XBE    6
`define MODE_PE     5
`define MODE_PT     4:3
`define MODE_DL     2:1
`define MODE_STOP2  0

`define BAUD_RELOAD 15:0
`define BAUD_PS     17:16
`define BAUD_EN     18

`define DL_5        2'h0
`define DL_BASE     3'h4

`define PT_ODD      2'h0
`define PT_EVEN     2'h1
`define PT_MARK     2'h2

`define PS_1        2'h0
`define PS_4        2'h1
`define PS_12       2'h2
`define DIV_1       6'h01
`define DIV_4       6'h04
`define DIV_12      6'h0c
`define DIV_48      6'h30

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define FIFO_DEPTH  3

`endif

// *** rtl/uart_pkg.sv ***
/*
 Types shared by the serial port files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package uart_pkg;
    typedef logic [31:0] word_t;
    typedef logic [7:0]  addr_t;
    typedef logic [1:0]  resp_t;
    typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_EXTRA, T_STOP1, T_STOP2} tx_state_t;
    typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_EXTRA, R_STOP1, R_STOP2} rx_state_t;
endpackage

// *** rtl/baud_gen.sv ***
/*
 Reload timer with prescaler; one tick per timer wrap, two ticks per bit.
 Assumes an asynchronous active-low reset already released cleanly.
*/
`timescale 1ns/1ns
`include "uart_cfg.svh"
module baud_gen #(
    parameter int TW = 16
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          enable,
    input  wire logic          restart,
    input  wire logic [TW-1:0] reload,
    input  wire logic [1:0]    presc_sel,
    output logic               tick
);
    if (TW < 8) begin : g_bad_width
        $error("baud_gen timer too narrow");
    end

    typedef struct packed {
        logic [5:0]    pcnt;
        logic [TW-1:0] timer;
        logic          tick;
    } bg_state_t;

    bg_state_t  s;
    bg_state_t  n;
    logic [5:0] last_p;

    always_comb begin
        n = s;
        n.tick = 1'b0;
        case (presc_sel)
            `PS_1:   last_p = `DIV_1 - 6'h01;
            `PS_4:   last_p = `DIV_4 - 6'h01;
            `PS_12:  last_p = `DIV_12 - 6'h01;
            default: last_p = `DIV_48 - 6'h01;
        endcase
        if (!enable || restart) begin
            n.pcnt  = '0;
            n.timer = reload;
        end else if (s.pcnt >= last_p) begin
            n.pcnt = '0;
            if (&s.timer) begin
                n.timer = reload;                                   // RL22
                n.tick  = 1'b1;
            end else begin
                n.timer = s.timer + 1'b1;                           // RL22
            end
        end else begin
            n.pcnt = s.pcnt + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_wrap_reload;
        enable && !restart && s.pcnt == last_p && &s.timer
            |=> tick && s.timer == $past(reload);
    endproperty
    a_wrap_reload: assert property (p_wrap_reload) else $error("timer did not reload"); // RL22

    property p_count_up;
        enable && !restart && s.pcnt == last_p && !(&s.timer)
            |=> !tick && s.timer == $past(s.timer) + 1'b1;
    endproperty
    a_count_up: assert property (p_count_up) else $error("timer did not count"); // RL22
endmodule // baud_gen

// *** rtl/uart_fifo_multiproc.sv ***
/*
 Full-duplex serial port with 3-byte receive FIFO, parity or extra bit,
 multiprocessor address filter, and an AXI4-Lite register slave.
 Assumes serial_in_pin is synchronous to clk and the bus master obeys AXI4-Lite.
*/
// How it works
// [RL1] Transmit and receive run independently, simultaneously
// [RL2] Software clears multiproc enable for two nodes
// [RL3] Data write fills holding register, clears empty
// [RL4] New byte waits while current frame shifts
// [RL5] Done flag set entering stop bit time
// [RL6] Extra bit sends software bit without parity
// [RL7] Parity computed and appended; no extra bit
// [RL8] Receiver starts frames only when enabled
// [RL9] Store byte if FIFO free and stops high
// [RL10] Full FIFO drops byte, sets overrun
// [RL11] Low stop bit frames are discarded
// [RL12] Stored byte sets receive done flag
// [RL13] Multiproc mode flags only frames whose extra bit, or first stop bit if none, is one
// [RL14] Data read returns oldest byte, frees entry
// [RL15] Receive done clears only when no byte waits behind head
// [RL16] Software drains with clear, read, check loop
// [RL17] Extra receive bit shows head extra/stop
// [RL18] Parity mismatch sets sticky parity error
// [RL19] Master sends address frames with extra one
// [RL20] Addressed slave toggles multiproc enable per message
// [RL21] Frame: start, 5-8 bits LSB first, extras, stops
// [RL22] Baud timer counts up, reloads on wrap
// [RL23] Two stops need 6+ bits; extra excludes parity
// [RL24] Start on falling edge, sample mid-bit
// [RL25] Holding empty returns once byte moves to shifter
`timescale 1ns/1ns
`include "uart_cfg.svh"
module uart_fifo_multiproc #(
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic            clk,
    input  wire logic            nrst,
    input  wire uart_pkg::addr_t awaddr,
    input  wire logic            awvalid,
    output logic                 awready,
    input  wire uart_pkg::word_t wdata,
    input  wire logic [3:0]      wstrb,
    input  wire logic            wvalid,
    output logic                 wready,
    output uart_pkg::resp_t      bresp,
    output logic                 bvalid,
    input  wire logic            bready,
    input  wire uart_pkg::addr_t araddr,
    input  wire logic            arvalid,
    output logic                 arready,
    output uart_pkg::word_t      rdata,
    output uart_pkg::resp_t      rresp,
    output logic                 rvalid,
    input  wire logic            rready,
    input  wire logic            serial_in_pin,
    output logic                 serial_out_pin
);
    import uart_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || DEPTH > 15) begin : g_bad_depth
        $error("receive FIFO depth out of range");
    end

    typedef struct packed {
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic aw_got;
        logic w_got;
        logic bvalid;
        logic rvalid;
        addr_t awaddr;
        word_t wdata;
        logic [3:0] wstrb;
        resp_t bresp;
        resp_t rresp;
        word_t rdata;
        logic ovr;
        logic perr;
        logic ren;
        logic tbx;
        logic ti;
        logic ri;
        logic mce;
        logic xbe;
        logic pe;
        logic stop2;
        logic [1:0] ptype;
        logic [1:0] dlen;
        logic [15:0] reload;
        logic [1:0] presc;
        logic ben;
        tx_state_t tstate;
        logic [7:0] hold;
        logic hold_full;
        logic [7:0] tdata;
        logic tx_x;
        logic thalf;
        logic [2:0] tidx;
        logic txd;
        rx_state_t rstate;
        logic rx_prev;
        logic rhalf;
        logic rx_x;
        logic rstop1;
        logic rstop_ok;
        logic [2:0] ridx;
        logic [7:0] rsh;
        logic [DEPTH-1:0][8:0] mem;
        logic [PW-1:0] rd_ptr;
        logic [PW-1:0] wr_ptr;
        logic [CW-1:0] count;
    } state_t;

    localparam state_t RST = '{aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1,
                               txd: 1'b1, rx_prev: 1'b1, tstate: T_IDLE,
                               rstate: R_IDLE, default: '0};

    state_t     s;
    state_t     n;
    logic [1:0] rst_sync;
    logic       rst_n;
    logic       aw_hs;
    logic       w_hs;
    logic       ar_hs;
    logic       wr_go;
    logic       pop;
    logic       push;
    logic       fin;
    logic       good;
    logic       xb;
    logic       ti_set;
    logic       tx_end;
    logic       rx_smp;
    logic       xbe_eff;
    logic       slot;
    logic       stop2_eff;
    logic [2:0] last;
    logic [8:0] head;
    logic       tx_restart;
    logic       rx_restart;
    logic       tx_tick;
    logic       rx_tick;

    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] dl,
                                     input logic [1:0] pt);
        logic [7:0] m;
        m = d & (8'hff >> (2'h3 - dl));
        case (pt)
            `PT_ODD:  par_bit = ~^m;
            `PT_EVEN: par_bit = ^m;
            `PT_MARK: par_bit = 1'b1;
            default:  par_bit = 1'b0;
        endcase
    endfunction

    function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
        inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Release is synchronous so no flop leaves reset on a split edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= '0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Separate timers so receive can realign to each start edge
    baud_gen #(.TW(16)) u_tx_baud (
        .clk       (clk),
        .rst_n     (rst_n),
        .enable    (s.ben),
        .restart   (tx_restart),
        .reload    (s.reload),
        .presc_sel (s.presc),
        .tick      (tx_tick)
    );

    baud_gen #(.TW(16)) u_rx_baud (
        .clk       (clk),
        .rst_n     (rst_n),
        .enable    (s.ben),
        .restart   (rx_restart),
        .reload    (s.reload),
        .presc_sel (s.presc),
        .tick      (rx_tick)
    );

    always_comb begin
        n = s;
        aw_hs = awvalid & s.aw_rdy;
        w_hs = wvalid & s.w_rdy;
        ar_hs = arvalid & s.ar_rdy;
        wr_go = s.aw_got & s.w_got & ~s.bvalid;
        pop = 1'b0;
        push = 1'b0;
        fin = 1'b0;
        good = 1'b0;
        ti_set = 1'b0;
        tx_restart = 1'b0;
        rx_restart = 1'b0;
        xbe_eff = s.xbe & ~s.pe;                                    // RL23
        slot = s.pe | xbe_eff;
        stop2_eff = s.stop2 & (s.dlen != `DL_5);                    // RL23
        last = `DL_BASE + {1'b0, s.dlen};
        head = (s.count != '0) ? s.mem[s.rd_ptr] : '0;
        tx_end = tx_tick & s.thalf;
        rx_smp = rx_tick & s.rhalf;

        // Transmitter, independent of the receiver
        if (s.tstate != T_IDLE && tx_tick) begin                    // RL1
            n.thalf = ~s.thalf;
        end
        case (s.tstate)
            T_IDLE: begin
                n.txd = 1'b1;
                if (s.hold_full) begin
                    n.tdata = s.hold;
                    n.tx_x = s.pe ? par_bit(s.hold, s.dlen, s.ptype) : s.tbx; // RL6 RL7
                    n.hold_full = 1'b0;                             // RL25
                    n.thalf = 1'b0;
                    n.tidx = '0;
                    n.txd = 1'b0;                                   // RL21
                    n.tstate = T_START;
                    tx_restart = 1'b1;
                end
            end
            T_START: if (tx_end) begin
                n.tstate = T_DATA;
                n.txd = s.tdata[0];
            end
            T_DATA: if (tx_end) begin
                if (s.tidx != last) begin
                    n.tidx = s.tidx + 3'h1;
                    n.tdata = s.tdata >> 1;
                    n.txd = s.tdata[1];
                end else if (slot) begin
                    n.tstate = T_EXTRA;
                    n.txd = s.tx_x;                                 // RL6 RL7
                end else begin
                    n.tstate = T_STOP1;
                    n.txd = 1'b1;
                    ti_set = 1'b1;                                  // RL5
                end
            end
            T_EXTRA: if (tx_end) begin
                n.tstate = T_STOP1;
                n.txd = 1'b1;
                ti_set = 1'b1;                                      // RL5
            end
            T_STOP1: if (tx_end) begin
                n.tstate = stop2_eff ? T_STOP2 : T_IDLE;            // RL23
            end
            default: if (tx_end) begin
                n.tstate = T_IDLE;
            end
        endcase

        // Receiver
        n.rx_prev = serial_in_pin;
        if (s.rstate != R_IDLE && rx_tick) begin
            n.rhalf = ~s.rhalf;
        end
        case (s.rstate)
            R_IDLE: if (s.ren && s.rx_prev && !serial_in_pin) begin // RL8 RL24
                n.rstate = R_START;
                n.rhalf = 1'b1;
                n.rsh = '0;
                n.ridx = '0;
                rx_restart = 1'b1;
            end
            R_START: if (rx_smp) begin
                n.rstate = serial_in_pin ? R_IDLE : R_DATA;         // RL24
            end
            R_DATA: if (rx_smp) begin
                n.rsh[s.ridx] = serial_in_pin;                      // RL21
                if (s.ridx != last) begin
                    n.ridx = s.ridx + 3'h1;
                end else begin
                    n.rstate = slot ? R_EXTRA : R_STOP1;
                end
            end
            R_EXTRA: if (rx_smp) begin
                n.rx_x = serial_in_pin;
                n.rstate = R_STOP1;
            end
            R_STOP1: if (rx_smp) begin
                n.rstop1 = serial_in_pin;
                n.rstop_ok = serial_in_pin;
                if (stop2_eff) begin
                    n.rstate = R_STOP2;
                end else begin
                    n.rstate = R_IDLE;
                    fin = 1'b1;
                end
            end
            default: if (rx_smp) begin
                n.rstop_ok = s.rstop_ok & serial_in_pin;
                n.rstate = R_IDLE;
                fin = 1'b1;
            end
        endcase
        good = fin & n.rstop_ok;                                    // RL11
        xb = xbe_eff ? s.rx_x : n.rstop1;
        push = good && s.count != CW'(DEPTH);                       // RL9

        // Bus writes
        if (aw_hs) begin
            n.aw_rdy = 1'b0;
            n.aw_got = 1'b1;
            n.awaddr = awaddr;
        end
        if (w_hs) begin
            n.w_rdy = 1'b0;
            n.w_got = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
            n.aw_rdy = 1'b1;
            n.w_rdy = 1'b1;
        end
        if (wr_go) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `RESP_OKAY;
            if (s.awaddr == `ADDR_CTRL) begin
                if (s.wstrb[0]) begin
                    n.ovr = s.wdata[`CTL_OVR];
                    n.perr = s.wdata[`CTL_PERR];
                    n.ren = s.wdata[`CTL_REN];
                    n.tbx = s.wdata[`CTL_TBX];
                    n.ti = s.wdata[`CTL_TI];
                    // Clear refused while bytes wait behind the head
                    n.ri = s.wdata[`CTL_RI] | (s.ri & (s.count > CW'(1))); // RL15
                end
            end else if (s.awaddr == `ADDR_DATA) begin
                if (s.wstrb[0]) begin
                    n.hold = s.wdata[7:0];                          // RL3 RL4
                    n.hold_full = 1'b1;                             // RL3
                end
            end else if (s.awaddr == `ADDR_MODE) begin
                if (s.wstrb[0]) begin
                    n.mce = s.wdata[`MODE_MCE];
                    n.xbe = s.wdata[`MODE_XBE];
                    n.pe = s.wdata[`MODE_PE];
                    n.ptype = s.wdata[`MODE_PT];
                    n.dlen = s.wdata[`MODE_DL];
                    n.stop2 = s.wdata[`MODE_STOP2];
                end
            end else if (s.awaddr == `ADDR_BAUD) begin
                if (s.wstrb[0]) begin
                    n.reload[7:0] = s.wdata[7:0];
                end
                if (s.wstrb[1]) begin
                    n.reload[15:8] = s.wdata[15:8];
                end
                if (s.wstrb[2]) begin
                    n.presc = s.wdata[`BAUD_PS];
                    n.ben = s.wdata[`BAUD_EN];
                end
            end else begin
                n.bresp = `RESP_SLVERR;
            end
        end

        // Bus reads
        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
            n.ar_rdy = 1'b1;
        end
        if (ar_hs) begin
            n.ar_rdy = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = `RESP_OKAY;
            n.rdata = '0;
            if (araddr == `ADDR_CTRL) begin
                n.rdata[7:0] = {s.ovr, s.perr, ~s.hold_full, s.ren,
                                s.tbx, head[8], s.ti, s.ri};        // RL17
            end else if (araddr == `ADDR_DATA) begin
                n.rdata[7:0] = head[7:0];                           // RL14
                pop = (s.count != '0);                              // RL14
            end else if (araddr == `ADDR_MODE) begin
                n.rdata[7:0] = {s.mce, s.xbe, s.pe, s.ptype, s.dlen, s.stop2};
            end else if (araddr == `ADDR_BAUD) begin
                n.rdata[18:0] = {s.ben, s.presc, s.reload};
            end else begin
                n.rresp = `RESP_SLVERR;
            end
        end

        // Hardware sets land after software writes so they win
        if (ti_set) begin
            n.ti = 1'b1;                                            // RL5
        end
        if (good && !push) begin
            n.ovr = 1'b1;                                           // RL10
        end
        if (push) begin
            n.mem[s.wr_ptr] = {xb, s.rsh};                          // RL9 RL17
            n.wr_ptr = inc(s.wr_ptr);
            if (!s.mce || xb) begin
                n.ri = 1'b1;                                        // RL12 RL13
            end
            if (s.pe && s.rx_x != par_bit(s.rsh, s.dlen, s.ptype)) begin
                n.perr = 1'b1;                                      // RL18
            end
        end
        if (pop) begin
            n.rd_ptr = inc(s.rd_ptr);                               // RL14
        end
        n.count = s.count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= RST;
        end else begin
            s <= n;
        end
    end

    assign awready = s.aw_rdy;
    assign wready = s.w_rdy;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.ar_rdy;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign serial_out_pin = s.txd;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence q_data_write;
        wr_go && s.awaddr == `ADDR_DATA && s.wstrb[0];
    endsequence

    sequence q_stop_entry;
        (s.tstate == T_DATA || s.tstate == T_EXTRA) ##1 s.tstate == T_STOP1;
    endsequence

    property p_thre_clear;
        q_data_write |=> s.hold_full;
    endproperty
    a_thre_clear: assert property (p_thre_clear) else $error("holding flag not set"); // RL3

    property p_hold_waits;
        s.hold_full && s.tstate != T_IDLE |=> s.hold_full;
    endproperty
    a_hold_waits: assert property (p_hold_waits) else $error("held byte lost early"); // RL4

    property p_hold_moves;
        s.hold_full && s.tstate == T_IDLE && !wr_go
            |=> !s.hold_full && s.tstate == T_START && !serial_out_pin;
    endproperty
    a_hold_moves: assert property (p_hold_moves) else $error("byte did not load"); // RL25

    property p_ti_at_stop;
        q_stop_entry |-> s.ti && serial_out_pin;
    endproperty
    a_ti_at_stop: assert property (p_ti_at_stop) else $error("done flag missing"); // RL5

    property p_extra_sw;
        s.tstate == T_IDLE && s.hold_full && !s.pe |=> s.tx_x == $past(s.tbx);
    endproperty
    a_extra_sw: assert property (p_extra_sw) else $error("wrong extra bit"); // RL6

    property p_parity_tx;
        s.tstate == T_IDLE && s.hold_full && s.pe
            |=> s.tx_x == par_bit($past(s.hold), $past(s.dlen), $past(s.ptype));
    endproperty
    a_parity_tx: assert property (p_parity_tx) else $error("wrong parity bit"); // RL7

    property p_rx_off;
        s.rstate == R_IDLE && !s.ren |=> s.rstate == R_IDLE;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("receiver ran disabled"); // RL8

    property p_overrun;
        good && s.count == CW'(DEPTH) && !pop |=> s.ovr && s.count == CW'(DEPTH);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // RL10

    property p_bad_stop;
        fin && !good && !pop |=> s.count == $past(s.count);
    endproperty
    a_bad_stop: assert property (p_bad_stop) else $error("bad frame stored"); // RL11

    property p_store;
        good && s.count < CW'(DEPTH) && !pop && !s.mce
            |=> s.ri && s.count == $past(s.count) + 1'b1;
    endproperty
    a_store: assert property (p_store) else $error("byte not stored"); // RL12

    property p_ri_hold;
        wr_go && s.awaddr == `ADDR_CTRL && s.wstrb[0] && !s.wdata[`CTL_RI] && s.ri
            && s.count > CW'(1) |=> s.ri;
    endproperty
    a_ri_hold: assert property (p_ri_hold) else $error("flag cleared too early"); // RL15

    property p_pop;
        pop && !push |=> s.count == $past(s.count) - 1'b1 && s.rvalid;
    endproperty
    a_pop: assert property (p_pop) else $error("read did not free entry"); // RL14
endmodule // uart_fifo_multiproc

// *** test/remote_node.sv ***
/* Remote serial node: sends frames on request, captures the block's frames.
 Assumes a bit time of BT clock cycles. */
`timescale 1ns/1ns
module remote_node #(
    parameter int BT = 4
) (
    input  wire logic clk,
    input  wire logic serial_out_pin,
    output logic      serial_in_pin
);
    logic [8:0] got_q[$];
    logic [8:0] sh;
    initial serial_in_pin = 1'b1;
    // Start, data LSB first, optional extra, stop, then idle high
    task automatic send(input logic [7:0] d, input logic xb, hasx, stp);
        logic [10:0] f;
        f = hasx ? {stp, xb, d, 1'b0} : {1'b1, stp, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            serial_in_pin <= f[i];
            repeat (BT) @(posedge clk);
        end
    endtask
    // Keeps the data and the bit after it, sampled mid-bit
    initial forever begin
        @(negedge serial_out_pin);
        repeat (BT / 2) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BT) @(posedge clk);
            sh[i] = serial_out_pin;
        end
        got_q.push_back(sh);
    end
endmodule // remote_node

// *** test/uart_fifo_multiproc_bench.sv ***
/* Bench of the serial port: bus tasks, a remote node, random bytes.
 Assumes the fast baud setting, a bit time of 4 clock cycles. */
`timescale 1ns/1ns
`include "uart_cfg.svh"
module uart_fifo_multiproc_bench;
    import uart_pkg::*;
    `define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
        $display("[ERR] %0t got %h exp %h", $time, a, e); end end
    logic clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic sin, sout;
    addr_t awaddr = '0, araddr = '0;
    word_t wdata = '0, rdata, w;
    resp_t bresp, rresp, r;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] d, q[4];
    int n_mismatch = 0, check_count = 0;
    uart_fifo_multiproc DUT (.clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .serial_in_pin(sin), .serial_out_pin(sout));
    remote_node P (.clk(clk), .serial_out_pin(sout), .serial_in_pin(sin));
    // Each bus task lets an edge pass first, so no signal is driven twice in one step
    task automatic wr(input addr_t a, input word_t v);
        @(posedge clk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        fork
            begin @(posedge clk iff awready); awvalid <= 1'b0; end
            begin @(posedge clk iff wready); wvalid <= 1'b0; end
        join
        @(posedge clk iff bvalid); bready <= 1'b0; r = bresp;
    endtask
    // Expected parity bit: even parity when odd is low
    function automatic logic par(input logic [7:0] v, input logic odd);
        return ^v ^ odd;
    endfunction
    task automatic rd(input addr_t a, output word_t v, output resp_t e);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        @(posedge clk iff arready); arvalid <= 1'b0;
        @(posedge clk iff rvalid); rready <= 1'b0; v = rdata; e = rresp;
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h50f3));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`ADDR_CTRL, w, r);
        `CHK(w, 32'h20)
        rd(8'h10, w, r);
        `CHK({w, r}, {32'h0, `RESP_SLVERR})
        wr(8'h10, 32'hff);
        `CHK(r, `RESP_SLVERR)
        wr(`ADDR_BAUD, 32'h0004fffe);
        `CHK(r, `RESP_OKAY)
        wr(`ADDR_MODE, 32'h06);
        for (int i = 0; i < 2; i++) begin
            q[i] = $urandom;
            wr(`ADDR_DATA, {24'h0, q[i]});
        end
        rd(`ADDR_CTRL, w, r);
        `CHK(w[5], 1'b0)
        wait (P.got_q.size() == 2);
        for (int i = 0; i < 2; i++) begin
            w[8:0] = P.got_q.pop_front();
            `CHK(w[8:0], {1'b1, q[i]})
        end
        rd(`ADDR_CTRL, w, r);
        `CHK({w[5], w[1]}, 2'b11)
        wr(`ADDR_MODE, 32'h46);
        for (int x = 0; x < 2; x++) begin
            d = $urandom;
            wr(`ADDR_CTRL, x << 3);
            wr(`ADDR_DATA, {24'h0, d});
            wait (P.got_q.size() == 1);
            w[8:0] = P.got_q.pop_front();
            `CHK(w[8:0], {x[0], d})
        end
        wr(`ADDR_MODE, 32'h06);
        P.send(8'ha5, 1'b0, 1'b0, 1'b1);
        wr(`ADDR_CTRL, 32'h10);
        P.send(8'h5a, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            q[i] = $urandom;
            P.send(q[i], 1'b0, 1'b0, 1'b1);
        end
        rd(`ADDR_CTRL, w, r);
        `CHK(w, 32'hb5)
        for (int i = 0; i < 3; i++) begin
            wr(`ADDR_CTRL, 32'h10);
            rd(`ADDR_CTRL, w, r);
            `CHK(w[0], i < 2)
            rd(`ADDR_DATA, w, r);
            `CHK(w, {24'h0, q[i]})
        end
        // Data, address, then data after the match; then bad even and good odd parity
        for (int k = 0; k < 5; k++) begin
            d = $urandom;
            w = k < 2 ? 32'hc6 : k == 2 ? 32'h46 : k == 3 ? 32'h2e : 32'h26;
            wr(`ADDR_MODE, w);
            wr(`ADDR_CTRL, 32'h10);
            if (k > 2) wr(`ADDR_DATA, {24'h0, d});
            P.send(d, k < 3 ? k == 1 : par(d, k == 4) ^ (k == 3), 1'b1, 1'b1);
            rd(`ADDR_CTRL, w, r);
            `CHK({w[6], w[0]}, {k == 3, k != 0})
            if (k < 3) `CHK(w[2], k == 1)
            rd(`ADDR_DATA, w, r);
            `CHK(w, {24'h0, d})
            if (k > 2) begin
                wait (P.got_q.size() == 1);
                w[8:0] = P.got_q.pop_front();
                `CHK(w[8:0], {par(d, k == 4), d})
            end
        end
        wrap_up();
    end
endmodule // uart_fifo_multiproc_bench
